//--- include/door_pkg.sv
// Purpose : shared constants and carriers for the guard door interlock
// Assumes : one 40 MHz scan clock, asynchronous active-low reset
// Notes   : config bits are plain ports, no register bus
//
// How it works
// R1 - door supervision acts only while door_function_enable is one.
// R2 - door opens in auto run: pause feed, coolant off, raise alarm.
// R3 - door closes: alarm clears, coolant returns, cycle start resumes program.
// R4 - stop-spindle select one halts spindle on door open; zero keeps it turning.
// R5 - spindle halted by the door stays off until a fresh start command.
// R6 - speed-limit select without stop-spindle: no alarm, coolant off, speeds capped.
// R7 - polarity zero means normally open switch, one means normally closed.
// R8 - auto coolant forced off under door alarm; manual coolant only without it.
// R9 - lock release allowed only while no automatic program executes.
package door_pkg;

    // =========================================================
    // widths and reset values
    localparam int          SPEED_W          = 16;
    localparam logic [15:0] SAFE_SPINDLE_RST = 16'h0064;
    localparam logic [15:0] SAFE_FEED_RST    = 16'h0064;
    localparam logic        SYNC_RST         = 1'b0;

    // =========================================================
    // configuration carrier
    typedef struct packed {
        logic door_function_enable;
        logic door_stop_spindle_sel;
        logic door_speed_limit_sel;
        logic door_input_polarity;
    } door_cfg_t;

    // machine state carrier from the motion core
    typedef struct packed {
        logic auto_mode;
        logic remote_mode;
        logic program_running;
    } run_state_t;

    typedef enum logic [1:0] {
        ST_CLOSED  = 2'b00,
        ST_ALARM   = 2'b01,
        ST_LIMITED = 2'b10,
        ST_IDLE    = 2'b11
    } door_state_t;

endpackage : door_pkg

//--- design/door_sync.sv
// Purpose : two-stage synchroniser for asynchronous pins
// Assumes : destination is the scan clock
// Notes   : first stage feeds only the second stage
`timescale 1ns/1ps
module door_sync
    import door_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_ff <= {WIDTH{SYNC_RST}};
            sync_ff <= {WIDTH{SYNC_RST}};
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : door_sync

//--- design/guard_door_interlock.sv
// Purpose : protective door supervision for automatic machining
// Assumes : door switch and coolant key arrive asynchronously; core signals are synchronous
// Notes   : spindle stays latched off after a door stop until a new start command
`timescale 1ns/1ps
module guard_door_interlock
    import door_pkg::*;
#(
    parameter int          SPEED_WIDTH  = SPEED_W,
    parameter logic [15:0] SAFE_SPINDLE = SAFE_SPINDLE_RST,
    parameter logic [15:0] SAFE_FEED    = SAFE_FEED_RST
)
(
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   nrst_i,
    // configuration
    input  wire door_cfg_t              cfg_i,
    // door switch pin
    input  wire logic                   door_alarm_in_i,
    // motion core
    input  wire run_state_t             run_i,
    input  wire logic                   cycle_start_i,
    input  wire logic                   spindle_start_i,
    input  wire logic                   spindle_stop_i,
    input  wire logic                   coolant_auto_i,
    input  wire logic [SPEED_WIDTH-1:0] spindle_speed_i,
    input  wire logic [SPEED_WIDTH-1:0] feed_rate_i,
    // operator panel
    input  wire logic                   coolant_key_i,
    // outputs
    output logic                        feed_hold_o,
    output logic                        feed_resume_o,
    output logic                        spindle_run_o,
    output logic                        coolant_pump_o,
    output logic                        door_open_alarm_o,
    output logic                        speed_limit_o,
    output logic [SPEED_WIDTH-1:0]      spindle_speed_o,
    output logic [SPEED_WIDTH-1:0]      feed_rate_o,
    output logic                        door_lock_release_out_o
);

    // =========================================================
    // elaboration checks
    // a safe speed wider than the port would be cut without warning
    if (SPEED_WIDTH < 1 || SPEED_WIDTH > 16)
    begin : g_bad_width
        $error("SPEED_WIDTH must lie between 1 and 16");
    end
    if ((SAFE_SPINDLE >> SPEED_WIDTH) != 16'h0000)
    begin : g_bad_spindle_cap
        $error("SAFE_SPINDLE does not fit SPEED_WIDTH");
    end
    if ((SAFE_FEED >> SPEED_WIDTH) != 16'h0000)
    begin : g_bad_feed_cap
        $error("SAFE_FEED does not fit SPEED_WIDTH");
    end

    // =========================================================
    // input synchronisation
    logic [1:0] pin_sync;

    door_sync #(.WIDTH(2)) u_sync
    (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i ({coolant_key_i, door_alarm_in_i}),
        .sync_o  (pin_sync)
    );

    wire door_pin     = pin_sync[0];
    wire coolant_key  = pin_sync[1];

    // =========================================================
    // decoding
    wire door_open    = door_pin ^ cfg_i.door_input_polarity;        // R7
    wire auto_run     = run_i.program_running &
                        (run_i.auto_mode | run_i.remote_mode);
    wire supervise    = cfg_i.door_function_enable & door_open & auto_run; // R1
    wire limit_mode   = cfg_i.door_speed_limit_sel & ~cfg_i.door_stop_spindle_sel;
    wire alarm_case   = supervise & ~limit_mode;                     // R2
    wire limit_case   = supervise & limit_mode;                      // R6
    wire spindle_trip = alarm_case & cfg_i.door_stop_spindle_sel;    // R4

    // =========================================================
    // state
    door_state_t state_ff;
    door_state_t nxt_state;
    door_state_t rest_state;
    logic        alarm_ff;
    logic        paused_ff;
    logic        spindle_ff;
    logic        manual_cool_ff;
    logic        key_prev_ff;
    logic        resume_ff;
    logic [SPEED_WIDTH-1:0] spd_ff;
    logic [SPEED_WIDTH-1:0] feed_ff;

    // where the machine settles once no door case holds
    assign rest_state = auto_run ? ST_CLOSED : ST_IDLE;

    always_comb
    begin
        case (state_ff)
            ST_CLOSED,
            ST_IDLE:
            begin
                if (alarm_case)
                    nxt_state = ST_ALARM;
                else if (limit_case)
                    nxt_state = ST_LIMITED;
                else
                    nxt_state = rest_state;
            end
            ST_ALARM:
            begin
                // alarm drops by itself once the synced door reads shut
                nxt_state = alarm_case ? ST_ALARM : rest_state; // R3
            end
            ST_LIMITED:
            begin
                nxt_state = limit_case ? ST_LIMITED : rest_state;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire key_edge     = coolant_key & ~key_prev_ff;
    wire nxt_alarm    = (nxt_state == ST_ALARM);
    wire door_blocks  = alarm_case | limit_case;
    // pause stays until operator presses cycle start with door shut
    wire nxt_paused   = alarm_case | (paused_ff & ~(cycle_start_i & ~door_blocks)); // R2 R3
    // spindle latch: a door trip wins over a start in the same cycle
    wire nxt_spindle  = spindle_trip ? 1'b0 :                        // R4
                        spindle_stop_i ? 1'b0 :
                        spindle_start_i ? 1'b1 : spindle_ff;         // R5
    // manual toggle refused while the door alarm stands
    wire nxt_manual   = (key_edge & ~alarm_ff & ~door_blocks) ?
                        ~manual_cool_ff : manual_cool_ff;            // R8
    wire nxt_resume   = paused_ff & ~nxt_paused;
    wire [SPEED_WIDTH-1:0] cap_spd  = SAFE_SPINDLE[SPEED_WIDTH-1:0];
    wire [SPEED_WIDTH-1:0] cap_feed = SAFE_FEED[SPEED_WIDTH-1:0];
    wire [SPEED_WIDTH-1:0] nxt_spd  = (limit_case && spindle_speed_i > cap_spd) ?
                                      cap_spd : spindle_speed_i;     // R6
    wire [SPEED_WIDTH-1:0] nxt_feed = (limit_case && feed_rate_i > cap_feed) ?
                                      cap_feed : feed_rate_i;        // R6

    // door state and alarm
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= ST_IDLE;
            alarm_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            alarm_ff <= nxt_alarm;
        end
    end

    // feed pause and its release pulse
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            paused_ff <= 1'b0;
            resume_ff <= 1'b0;
        end
        else
        begin
            paused_ff <= nxt_paused;
            resume_ff <= nxt_resume;
        end
    end

    // spindle latch and manual coolant toggle
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            spindle_ff     <= 1'b0;
            manual_cool_ff <= 1'b0;
            key_prev_ff    <= 1'b0;
        end
        else
        begin
            spindle_ff     <= nxt_spindle;
            manual_cool_ff <= nxt_manual;
            key_prev_ff    <= coolant_key;
        end
    end

    // speed outputs, registered so a cap never glitches the core
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            spd_ff  <= '0;
            feed_ff <= '0;
        end
        else
        begin
            spd_ff  <= nxt_spd;
            feed_ff <= nxt_feed;
        end
    end

    // =========================================================
    // outputs
    // coolant returns once both the door block and alarm_ff have dropped, no latch needed
    wire cool_auto_on = coolant_auto_i & auto_run;
    assign coolant_pump_o          = ~door_blocks & ~alarm_ff &
                                     (cool_auto_on | manual_cool_ff); // R2 R3 R6 R8
    assign door_open_alarm_o       = alarm_ff;                       // R2
    assign feed_hold_o             = paused_ff;                      // R2
    assign feed_resume_o           = resume_ff;                      // R3
    assign spindle_run_o           = spindle_ff;                     // R4
    assign speed_limit_o           = (state_ff == ST_LIMITED);       // R6
    assign spindle_speed_o         = spd_ff;
    assign feed_rate_o             = feed_ff;
    assign door_lock_release_out_o = ~run_i.program_running;         // R9

endmodule : guard_door_interlock

//--- verif/door_partner.sv
// Purpose: door switch model feeding the interlock pin
// Assumes: open_i is the physical door state
// Notes: pin level follows the configured contact type
`timescale 1ns/1ps
module door_partner
(
    input  wire logic open_i,
    input  wire logic polarity_i,
    output logic      door_alarm_in_o
);
    assign door_alarm_in_o = open_i ^ polarity_i;
endmodule : door_partner

//--- verif/guard_door_interlock_chk.sv
// Purpose: port-level checks of the door interlock
// Assumes: one scan clock, async low reset
// Notes: attached by bind
`timescale 1ns/1ps
module guard_door_interlock_chk
    import door_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       nrst_i,
    input wire door_cfg_t  cfg_i,
    input wire run_state_t run_i,
    input wire logic       spindle_start_i,
    input wire logic       feed_hold_o,
    input wire logic       feed_resume_o,
    input wire logic       spindle_run_o,
    input wire logic       coolant_pump_o,
    input wire logic       door_open_alarm_o,
    input wire logic       speed_limit_o,
    input wire logic       door_lock_release_out_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_trip_stop;
        $rose(door_open_alarm_o) ##0 cfg_i.door_stop_spindle_sel;
    endsequence
    sequence s_resume;
        $rose(feed_resume_o);
    endsequence
    chk_lock_idle: assert property (door_lock_release_out_o == !run_i.program_running)
        else $error("lock release wrong");
    chk_off_quiet: assert property (!cfg_i.door_function_enable [*2] |-> !door_open_alarm_o)
        else $error("alarm while disabled");
    chk_alarm_cause: assert property ($rose(door_open_alarm_o)
        |-> $past(run_i.program_running) && $past(cfg_i.door_function_enable))
        else $error("alarm without auto run");
    chk_alarm_hold: assert property (door_open_alarm_o |-> feed_hold_o)
        else $error("alarm without feed hold");
    chk_alarm_coolant: assert property (door_open_alarm_o |-> !coolant_pump_o)
        else $error("coolant on under alarm");
    chk_trip_spindle: assert property (s_trip_stop |-> !spindle_run_o)
        else $error("spindle not halted");
    chk_spindle_start: assert property ($rose(spindle_run_o) |-> $past(spindle_start_i))
        else $error("spindle restarted by itself");
    chk_resume_pulse: assert property (s_resume |-> $past(feed_hold_o) ##1 !feed_resume_o)
        else $error("bad resume pulse");
    chk_limit_quiet: assert property (speed_limit_o |-> !door_open_alarm_o)
        else $error("alarm in limit case");
endmodule : guard_door_interlock_chk

bind guard_door_interlock guard_door_interlock_chk u_chk (.clock_i, .nrst_i, .cfg_i, .run_i,
    .spindle_start_i, .feed_hold_o, .feed_resume_o, .spindle_run_o, .coolant_pump_o,
    .door_open_alarm_o, .speed_limit_o, .door_lock_release_out_o);

//--- verif/testbench.sv
// Purpose: self-checking bench for the door interlock
// Assumes: inputs change at falling edges
// Notes: config only changes with no program running
`timescale 1ns/1ps
module testbench;
    import door_pkg::*;
    logic        clock_i = 0, nrst_i = 0, open = 0, cs = 0, ss = 0, ca = 0, st = 0, ck = 0;
    logic        fh, fres, sr, cp, al, sl, lr, pin;
    logic [15:0] spd = 16'h0, fr = 16'h0, so, fo;
    door_cfg_t   cfg = '0;
    run_state_t  run = '0;
    int          num_errors = 0, tests_run = 0, seed = 78;
    initial forever #12.5 clock_i = ~clock_i;
    door_partner u_sw (.open_i(open), .polarity_i(cfg.door_input_polarity), .door_alarm_in_o(pin));
    guard_door_interlock dut (.clock_i(clock_i), .nrst_i(nrst_i), .cfg_i(cfg),
        .door_alarm_in_i(pin), .run_i(run), .cycle_start_i(cs), .spindle_start_i(ss),
        .spindle_stop_i(st), .coolant_auto_i(ca), .spindle_speed_i(spd), .feed_rate_i(fr),
        .coolant_key_i(ck), .feed_hold_o(fh), .feed_resume_o(fres), .spindle_run_o(sr),
        .coolant_pump_o(cp), .door_open_alarm_o(al), .speed_limit_o(sl), .spindle_speed_o(so),
        .feed_rate_o(fo), .door_lock_release_out_o(lr));
    function automatic logic [15:0] cap(input logic [15:0] v, input logic [15:0] l);
        return (v > l) ? l : v;
    endfunction : cap
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic chkb(input logic s, input logic e);
        chk({15'h0, s}, {15'h0, e});
    endtask : chkb
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    // reconfigure idle: pin sync lag would fake a door event mid-run
    task automatic setup(input door_cfg_t c, input run_state_t r);
        run = '0;
        cfg = c;
        tick(4);
        run = r;
        tick(1);
    endtask : setup
    task automatic tally_and_finish;
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #50000;
        num_errors++;
        tally_and_finish;
    end
    initial
    begin
        tick(12);
        nrst_i = 1;
        ca = 1;
        chkb(al, 1'h0); chkb(lr, 1'h1);
        for (int k = 0; k < 4; k++)
        begin
            setup({1'b1, k[1], 1'b0, k[0]}, {!k[0], k[0], 1'b1});
            chkb(lr, 1'h0);
            ss = 1; tick(1); ss = 0;
            open = 1; tick(4);
            chkb(al, 1'h1); chkb(fh, 1'h1); chkb(cp, 1'h0);
            chkb(sr, !k[1]);
            open = 0; tick(4);
            chkb(al, 1'h0); chkb(cp, 1'h1); chkb(fh, 1'h1);
            chkb(sr, !k[1]);
            cs = 1; tick(1); cs = 0;
            chkb(fres, 1'h1); chkb(fh, 1'h0);
        end
        setup(4'b1010, 3'b101);
        for (int i = 0; i < 6; i++)
        begin
            // corners first: exactly at the cap, then just below it
            spd = (i == 0) ? SAFE_SPINDLE_RST : 16'($random(seed));
            fr = (i == 1) ? SAFE_FEED_RST - 16'h0001 : 16'($random(seed));
            open = 1; tick(4);
            chkb(al, 1'h0); chkb(sl, 1'h1); chkb(cp, 1'h0); chkb(fh, 1'h0);
            chk(so, cap(spd, SAFE_SPINDLE_RST)); chk(fo, cap(fr, SAFE_FEED_RST));
            open = 0; tick(4);
            chkb(sl, 1'h0); chk(so, spd); chk(fo, fr);
        end
        // manual coolant key with the automatic request off
        ca = 0;
        setup(4'b1000, 3'b101);
        ck = 1; tick(4); ck = 0; tick(4);
        chkb(cp, 1'h1);
        open = 1; tick(4);
        chkb(cp, 1'h0); chkb(al, 1'h1);
        ck = 1; tick(4); ck = 0; tick(4);
        open = 0; tick(4);
        chkb(al, 1'h0); chkb(cp, 1'h1);
        ck = 1; tick(4); ck = 0; tick(4);
        chkb(cp, 1'h0);
        ss = 1; tick(1); ss = 0;
        chkb(sr, 1'h1);
        st = 1; tick(1); st = 0;
        chkb(sr, 1'h0);
        cs = 1; tick(1); cs = 0;
        chkb(fres, 1'h1); chkb(fh, 1'h0);
        ca = 1;
        setup(4'b0000, 3'b101);
        open = 1; tick(4);
        chkb(al, 1'h0); chkb(cp, 1'h1); chkb(fh, 1'h0);
        tally_and_finish;
    end
endmodule : testbench
